/* hw/fspc_top.sv */
// Flash self-programming controller: mode entry, halt release, commands.
// Assumes the CPU stalls on o_cpu_stall and reports its HALT instruction.
//
// Contract
// (RULE1) Erased block reads back all ones
// (RULE2) Firmware keeps CPU clock at least 1 MHz
// (RULE3) Firmware runs NOP then HALT after entry
// (RULE4) Entry halt self-releases after 10 us+2
// (RULE5) Firmware waits 8 us on crystal clock
// (RULE6) Firmware tests error flag by bit
// (RULE7) Pins hold halt state in self mode
// (RULE8) External security ignored in self mode
// (RULE9) Only protect byte blocks write/erase
// (RULE10) Firmware clears upper high-pointer bits
// (RULE11) Firmware zeroes command register around switches
// (RULE12) No interrupt service in self mode
// (RULE13) CPU stalls while a command runs
// (RULE14) Interrupts stay pending until normal mode
// (RULE15) Mode changes only by guarded sequence
// (RULE16) Reset aborts operation, returns normal mode
`timescale 1ns/10ps
module fspc_top #(
  parameter int NBLK     = 4,                      // Flash blocks
  parameter int BSZ      = 8,                      // Bytes per block
  parameter int BUSY_CYC = fspc_pkg::CMD_BUSY_CYC  // Command length
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rst,
  input  wire logic [7:0]      i_addr,
  input  wire logic [7:0]      i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [7:0]      o_rdata,
  input  wire logic            i_cpu_halt,
  output logic                 o_cpu_stall,
  output logic                 o_pin_hold,
  input  wire logic [NBLK-1:0] i_protect_blocks,
  input  wire logic [7:0]      i_irq_req,
  input  wire logic [7:0]      i_irq_ack,
  output logic      [7:0]      o_irq_pending
);
  localparam int DEPTH = NBLK * BSZ;
  localparam int ABITS = $clog2(DEPTH);
  localparam int BBITS = $clog2(BSZ);
  localparam int KBITS = ABITS - BBITS;
  localparam logic [11:0] HALT_LAST = 12'(fspc_pkg::HALT_REL_CYC - 1);
  localparam logic [11:0] BUSY_LAST = 12'(BUSY_CYC - 1);

  // Block numbers must fit the low bits of the high pointer
  if ((NBLK < 2) || (NBLK > 16) ||
      (BUSY_CYC < 2) || (BUSY_CYC > 4095)) begin : g_bad
    $error("fspc_top: NBLK or BUSY_CYC out of range");
  end

  // Address match, shared by the write and read decoders
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] b);
    return a == b;
  endfunction : hit

  fspc_pkg::fspc_state_type state, next_state;
  logic [11:0]     cnt, next_cnt;    // Halt and busy timer
  logic [7:0]      fcmd;             // Flash command register
  logic [7:0]      apl;              // Address pointer low
  logic [7:0]      aph;              // Address pointer high
  logic [7:0]      aphc;             // High compare
  logic [7:0]      wdat;             // Byte for write command
  logic [7:0]      mask;             // Interrupt mask 0
  logic [7:0]      pend;             // Pending interrupt requests
  logic            perr;             // Protect error flag
  logic            bfail;            // Blank check failed
  logic [NBLK-1:0] prot_s1;          // Synchroniser, first stage
  logic [NBLK-1:0] prot_s2;          // Synchronised protect byte
  logic            mode;             // Guarded mode bit
  logic            gfail;            // Guard sequence broken
  logic [7:0]      rd_val;           // Read mux output

  fspc_arr_if #(.ABITS(ABITS)) arr ();

  // Writes are dropped while a command runs; the CPU is stalled anyway
  logic wr_ok, wr_pmc, wr_pcmd, wr_stat, wr_fcmd;
  assign wr_ok   = i_wr && (state != fspc_pkg::ST_BUSY);
  assign wr_pmc  = wr_ok && hit(i_addr, fspc_pkg::A_PMC);
  assign wr_pcmd = wr_ok && hit(i_addr, fspc_pkg::A_PCMD);
  assign wr_stat = wr_ok && hit(i_addr, fspc_pkg::A_STAT);
  assign wr_fcmd = wr_ok && hit(i_addr, fspc_pkg::A_FCMD);

  // Command start decode, only once the entry halt has released
  logic [KBITS-1:0] blk;
  logic start, modify, known, reject, go;
  assign blk    = aph[KBITS-1:0];
  assign start  = wr_fcmd && (state == fspc_pkg::ST_READY) &&
                  (i_wdata != fspc_pkg::CMD_NONE);
  assign modify = (i_wdata == fspc_pkg::CMD_WRITE) ||
                  (i_wdata == fspc_pkg::CMD_ERASE);
  assign known  = modify || (i_wdata == fspc_pkg::CMD_BLANK);
  // (RULE8) no external security check
  // (RULE9) protect byte rejects
  assign reject = start && modify && prot_s2[blk];
  assign go     = start && known && !reject;

  // Array strobes; pointer registers hold still while busy
  assign arr.we    = go && (i_wdata == fspc_pkg::CMD_WRITE);
  assign arr.erase = go && (i_wdata == fspc_pkg::CMD_ERASE);
  assign arr.addr  = {blk, apl[BBITS-1:0]};
  assign arr.wdata = wdat;

  fspc_array #(
    .NBLK (NBLK),
    .BSZ  (BSZ)
  ) u_array (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .arr       (arr)
  );

  // (RULE15) guarded mode entry
  fspc_guard u_guard (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_key_wr  (wr_pcmd && (i_wdata == fspc_pkg::PROT_KEY)),
    .i_pmc_wr  (wr_pmc),
    .i_any_wr  (wr_ok),
    .i_wdata   (i_wdata),
    .o_mode    (mode),
    .o_fail    (gfail)
  );

  // Mode sequencer: entry, automatic halt release, command run
  always_comb begin
    next_state = state;
    next_cnt   = 12'h000;
    case (state)
      fspc_pkg::ST_NORMAL: begin
        if (mode) next_state = fspc_pkg::ST_ENTERED;
      end
      fspc_pkg::ST_ENTERED: begin
        if (!mode) next_state = fspc_pkg::ST_NORMAL;
        else if (i_cpu_halt) next_state = fspc_pkg::ST_HALT;
      end
      fspc_pkg::ST_HALT: begin
        // (RULE4) release without interrupt
        if (cnt == HALT_LAST) next_state = fspc_pkg::ST_READY;
        else next_cnt = cnt + 12'h001;
      end
      fspc_pkg::ST_READY: begin
        if (!mode) next_state = fspc_pkg::ST_NORMAL;
        else if (go) next_state = fspc_pkg::ST_BUSY;
      end
      default: begin
        // Fixed command time, then back to ready
        if (cnt == BUSY_LAST) next_state = fspc_pkg::ST_READY;
        else next_cnt = cnt + 12'h001;
      end
    endcase
  end

  // (RULE16) reset aborts to normal
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= fspc_pkg::ST_NORMAL;
      cnt   <= 12'h000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // (RULE13) CPU stalled while busy
  assign o_cpu_stall = (state == fspc_pkg::ST_HALT) ||
                       (state == fspc_pkg::ST_BUSY);

  // (RULE7) pins frozen in mode
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) o_pin_hold <= 1'b0;
    else o_pin_hold <= (next_state != fspc_pkg::ST_NORMAL);
  end

  // Protect byte is a pin-level strap; two flops before use
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      prot_s1 <= '0;
      prot_s2 <= '0;
    end else begin
      prot_s1 <= i_protect_blocks;
      prot_s2 <= prot_s1;
    end
  end

  // Software registers; the command code stays until rewritten
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      fcmd <= fspc_pkg::RST_ZERO;
      apl  <= fspc_pkg::RST_ZERO;
      aph  <= fspc_pkg::RST_ZERO;
      aphc <= fspc_pkg::RST_ZERO;
      wdat <= fspc_pkg::RST_ZERO;
      mask <= fspc_pkg::RST_MASK;
    end else begin
      if (wr_fcmd) fcmd <= i_wdata;
      if (wr_ok && hit(i_addr, fspc_pkg::A_APL)) apl <= i_wdata;
      if (wr_ok && hit(i_addr, fspc_pkg::A_APH)) aph <= i_wdata;
      if (wr_ok && hit(i_addr, fspc_pkg::A_APHC)) aphc <= i_wdata;
      if (wr_ok && hit(i_addr, fspc_pkg::A_WDAT)) wdat <= i_wdata;
      if (wr_ok && hit(i_addr, fspc_pkg::A_MASK)) mask <= i_wdata;
    end
  end

  // Status flags: a new event beats a same-cycle software clear
  logic perr_set, perr_clr, bl_end, bfail_clr;
  assign perr_set  = reject || gfail;
  assign perr_clr  = wr_stat && !i_wdata[fspc_pkg::PERR_BIT];
  assign bl_end    = (state == fspc_pkg::ST_BUSY) && (cnt == BUSY_LAST) &&
                     (fcmd == fspc_pkg::CMD_BLANK);
  assign bfail_clr = wr_stat && !i_wdata[fspc_pkg::BLNK_BIT];
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      perr  <= 1'b0;
      bfail <= 1'b0;
    end else begin
      perr  <= perr_set || (perr && !perr_clr);
      if (bl_end) bfail <= !arr.blank;
      else if (bfail_clr) bfail <= 1'b0;
    end
  end

  // (RULE14) requests kept pending
  // (RULE12) masked while in mode
  logic [7:0] next_pend;
  assign next_pend = i_irq_req | (pend & ~i_irq_ack);
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pend          <= 8'h00;
      o_irq_pending <= 8'h00;
    end else begin
      pend          <= next_pend;
      o_irq_pending <= (next_state == fspc_pkg::ST_NORMAL) ?
                       (next_pend & ~mask) : 8'h00;
    end
  end

  // Read decode; unmapped offsets read as zero
  always_comb begin
    if (hit(i_addr, fspc_pkg::A_PMC)) rd_val = {7'h00, mode};
    else if (hit(i_addr, fspc_pkg::A_STAT)) rd_val = {6'h00, bfail, perr};
    else if (hit(i_addr, fspc_pkg::A_FCMD)) rd_val = fcmd;
    else if (hit(i_addr, fspc_pkg::A_APL)) rd_val = apl;
    else if (hit(i_addr, fspc_pkg::A_APH)) rd_val = aph;
    else if (hit(i_addr, fspc_pkg::A_APHC)) rd_val = aphc;
    else if (hit(i_addr, fspc_pkg::A_WDAT)) rd_val = wdat;
    else if (hit(i_addr, fspc_pkg::A_RDAT)) rd_val = arr.rdata;
    else if (hit(i_addr, fspc_pkg::A_MASK)) rd_val = mask;
    else rd_val = 8'h00;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) o_rdata <= 8'h00;
    else o_rdata <= i_rd ? rd_val : 8'h00;
  end

  property p_halt_bound;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state == fspc_pkg::ST_HALT) |-> (cnt <= HALT_LAST);
  endproperty
  a_halt_bound: assert property (p_halt_bound) // RULE4
    else $error("halt timer past release count");

  property p_halt_release;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state == fspc_pkg::ST_HALT) && (cnt == HALT_LAST)
      |=> (state == fspc_pkg::ST_READY) && !o_cpu_stall;
  endproperty
  a_halt_release: assert property (p_halt_release) // RULE4
    else $error("halt not released on time");

  property p_pin_hold;
    @(posedge i_sys_clk) disable iff (i_rst)
    o_pin_hold == (state != fspc_pkg::ST_NORMAL);
  endproperty
  a_pin_hold: assert property (p_pin_hold) // RULE7
    else $error("pin hold disagrees with mode");

  property p_reject;
    @(posedge i_sys_clk) disable iff (i_rst)
    reject |-> !arr.we && !arr.erase ##1 perr && (state != fspc_pkg::ST_BUSY);
  endproperty
  a_reject: assert property (p_reject) // RULE9
    else $error("protected block modified");

  property p_busy_stall;
    @(posedge i_sys_clk) disable iff (i_rst)
    go |=> o_cpu_stall [*2] ##0 (state == fspc_pkg::ST_BUSY);
  endproperty
  a_busy_stall: assert property (p_busy_stall) // RULE13
    else $error("CPU not stalled during command");

  property p_no_service;
    @(posedge i_sys_clk) disable iff (i_rst)
    (state != fspc_pkg::ST_NORMAL) |-> (o_irq_pending == 8'h00);
  endproperty
  a_no_service: assert property (p_no_service) // RULE12
    else $error("interrupt offered in self mode");

  property p_keep_pending;
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_irq_req != 8'h00) |=> ((pend & $past(i_irq_req)) == $past(i_irq_req));
  endproperty
  a_keep_pending: assert property (p_keep_pending) // RULE14
    else $error("interrupt request lost");
endmodule : fspc_top

/* hw/fspc_pkg.sv */
// Constants for the flash self-programming controller: map, codes, timing.
// Assumes a single 250 MHz system clock shared by all fspc modules.
package fspc_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] A_PMC  = 8'h00; // Mode control, guarded
  localparam logic [7:0] A_PCMD = 8'h01; // Protect command (key)
  localparam logic [7:0] A_STAT = 8'h02; // Flash status
  localparam logic [7:0] A_FCMD = 8'h03; // Flash command
  localparam logic [7:0] A_APL  = 8'h04; // Address pointer low
  localparam logic [7:0] A_APH  = 8'h05; // Address pointer high
  localparam logic [7:0] A_APHC = 8'h06; // High compare
  localparam logic [7:0] A_WDAT = 8'h07; // Write data
  localparam logic [7:0] A_RDAT = 8'h08; // Flash byte at pointer
  localparam logic [7:0] A_MASK = 8'h09; // Interrupt mask 0
  // Field positions
  localparam int MODE_BIT = 0;           // Mode control: self mode
  localparam int PERR_BIT = 0;           // Status: protect error
  localparam int BLNK_BIT = 1;           // Status: blank check failed
  // Reset values
  localparam logic [7:0] RST_MASK = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Key and flash commands
  localparam logic [7:0] PROT_KEY  = 8'ha5;
  localparam logic [7:0] CMD_NONE  = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h03;
  localparam logic [7:0] CMD_BLANK = 8'h04;
  localparam logic [7:0] CMD_WRITE = 8'h05;
  localparam logic [7:0] BLANK_VAL = 8'hff;
  // Timing: halt settle in microseconds, then cycles at the clock rate
  localparam int CLK_MHZ        = 250;
  localparam int HALT_SETTLE_US = 10;
  localparam int HALT_EXTRA_CYC = 2;
  localparam int HALT_REL_CYC   = HALT_SETTLE_US * CLK_MHZ + HALT_EXTRA_CYC;
  localparam int CMD_BUSY_CYC   = 16;
  // Controller states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_NORMAL  = 3'b000,
    ST_ENTERED = 3'b001,
    ST_HALT    = 3'b011,
    ST_READY   = 3'b010,
    ST_BUSY    = 3'b110
  } fspc_state_type;
  // Guarded write sequence states
  typedef enum logic [1:0] {
    G_IDLE = 2'b00,
    G_KEY  = 2'b01,
    G_VAL  = 2'b11
  } fspc_guard_type;
endpackage : fspc_pkg

/* hw/fspc_arr_if.sv */
// Interface between the controller and its flash byte array.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface fspc_arr_if #(parameter int ABITS = 5);
  logic             we;     // Byte write pulse
  logic             erase;  // Block erase pulse
  logic [ABITS-1:0] addr;   // Byte address, block in upper bits
  logic [7:0]       wdata;  // Byte to write
  logic [7:0]       rdata;  // Registered byte at addr
  logic             blank;  // Addressed block is all blank
  modport ctl (output we, erase, addr, wdata, input rdata, blank);
  modport mem (input we, erase, addr, wdata, output rdata, blank);
endinterface : fspc_arr_if

/* hw/fspc_array.sv */
// Flash byte array kept in flip-flops, with block erase and blank test.
// Assumes the controller holds addr steady around an erase.
`timescale 1ns/10ps
module fspc_array #(
  parameter int NBLK = 4,
  parameter int BSZ  = 8
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  fspc_arr_if.mem   arr
);
  localparam int DEPTH = NBLK * BSZ;
  localparam int ABITS = $clog2(DEPTH);
  localparam int BBITS = $clog2(BSZ);

  // Sizes must be powers of two so block and byte split cleanly
  if ((BSZ < 2) || ((BSZ & (BSZ - 1)) != 0) ||
      ((NBLK & (NBLK - 1)) != 0)) begin : g_bad
    $error("fspc_array: sizes must be powers of two");
  end

  logic [7:0]       mem [DEPTH];  // Storage, no reset on purpose
  logic [DEPTH-1:0] is_ff;        // Byte holds the blank value
  logic [ABITS-1:0] base;         // First byte of addressed block

  assign base = {arr.addr[ABITS-1:BBITS], {BBITS{1'b0}}};

  // Per byte: erase wins over write, contents survive reset
  for (genvar i = 0; i < DEPTH; i++) begin : g_byte
    always_ff @(posedge i_sys_clk) begin
      // (RULE1) erase fills blank
      if (arr.erase && (base == ABITS'(i - (i % BSZ)))) begin
        mem[i] <= fspc_pkg::BLANK_VAL;
      end else if (arr.we && (arr.addr == ABITS'(i))) begin
        mem[i] <= arr.wdata;
      end
    end
    assign is_ff[i] = (mem[i] == fspc_pkg::BLANK_VAL);
  end

  // Blank when every byte of the block reads all ones
  assign arr.blank = &is_ff[base +: BSZ];

  // Registered read of the addressed byte
  always_ff @(posedge i_sys_clk) begin
    arr.rdata <= mem[arr.addr];
  end

  property p_erase_blank;
    @(posedge i_sys_clk) disable iff (i_rst)
    arr.erase ##1 $stable(arr.addr) |-> arr.blank;
  endproperty
  a_erase_blank: assert property (p_erase_blank) // RULE1
    else $error("erased block not blank");
endmodule : fspc_array

/* hw/fspc_guard.sv */
// Guarded write sequence for the self-programming mode bit.
// Assumes write strobes are one-cycle pulses from the register port.
`timescale 1ns/10ps
module fspc_guard (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_key_wr,   // Key written to protect command
  input  wire logic       i_pmc_wr,   // Write to mode control
  input  wire logic       i_any_wr,   // Any register write
  input  wire logic [7:0] i_wdata,
  output logic            o_mode,     // Self-programming mode bit
  output logic            o_fail      // Pulse: sequence broken
);
  fspc_pkg::fspc_guard_type gst, next_gst;
  logic [7:0] hold, next_hold;        // First value of the pair
  logic       next_mode, next_fail;
  logic       match;

  assign match = i_pmc_wr && (i_wdata == ~hold);

  // Key, value, inverted value; anything else aborts the sequence
  always_comb begin
    next_gst  = gst;
    next_hold = hold;
    next_mode = o_mode;
    next_fail = 1'b0;
    case (gst)
      fspc_pkg::G_IDLE: begin
        if (i_key_wr) next_gst = fspc_pkg::G_KEY;
        // (RULE15) lone write refused
        else if (i_pmc_wr) next_fail = 1'b1;
      end
      fspc_pkg::G_KEY: begin
        if (i_pmc_wr) begin
          next_gst  = fspc_pkg::G_VAL;
          next_hold = i_wdata;
        end else if (i_any_wr) begin
          next_gst  = fspc_pkg::G_IDLE;
          next_fail = 1'b1;
        end
      end
      default: begin
        // (RULE15) commit on complement
        if (match) next_mode = hold[fspc_pkg::MODE_BIT];
        if (i_any_wr) begin
          next_gst  = fspc_pkg::G_IDLE;
          next_fail = !match;
        end
      end
    endcase
  end

  // Reset drops back to normal mode
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      gst    <= fspc_pkg::G_IDLE;
      hold   <= fspc_pkg::RST_ZERO;
      o_mode <= 1'b0;
      o_fail <= 1'b0;
    end else begin
      gst    <= next_gst;
      hold   <= next_hold;
      o_mode <= next_mode;
      o_fail <= next_fail;
    end
  end

  property p_lone_write;
    @(posedge i_sys_clk) disable iff (i_rst)
    (gst == fspc_pkg::G_IDLE) && i_pmc_wr |=> $stable(o_mode) && o_fail;
  endproperty
  a_lone_write: assert property (p_lone_write) // RULE15
    else $error("ordinary write changed mode");
endmodule : fspc_guard

/* test/fspc_cpu_model.sv */
// Firmware stand-in: NOP then HALT after mode entry, then settle wait.
// Assumes the controller clock and sees the controller stall output.
`timescale 1ns/10ps
module fspc_cpu_model #(
  parameter int WAIT_CYC = 2000  // Settle after release: 8 us at 250 MHz
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  input  wire logic i_go,      // Entry sequence just written
  input  wire logic i_stall,   // Controller holds the CPU
  output logic      o_halt,    // HALT executed, one cycle
  output logic      o_ready    // Free to issue commands
);
  logic [2:0]  step;  // 0 idle, 1 nop, 2 halt, 3 held, 4 settle
  logic [15:0] cnt;   // Settle counter
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      step    <= 3'h0;
      cnt     <= 16'h0;
      o_halt  <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      case (step)
        3'h0: if (i_go) begin
          step    <= 3'h1;
          o_ready <= 1'b0;
        end
        // The NOP slot, then the HALT pulse
        3'h1: begin
          o_halt <= 1'b1;
          step   <= 3'h2;
        end
        3'h2: begin
          o_halt <= 1'b0;
          step   <= i_stall ? 3'h3 : 3'h2;
        end
        3'h3: if (!i_stall) begin
          step <= 3'h4;
          cnt  <= 16'h0;
        end
        // No command until the settle time is over
        default: begin
          cnt <= cnt + 16'h1;
          if (cnt == 16'(WAIT_CYC)) begin
            o_ready <= 1'b1;
            step    <= 3'h0;
          end
        end
      endcase
    end
  end
endmodule : fspc_cpu_model

/* test/flash_self_program_control_test.sv */
// Bench for the self-programming controller, register sequences plus interrupt pulses and a mid-erase reset.
// Assumes default sizes: 4 blocks of 8 bytes, 16-cycle commands.
`timescale 1ns/10ps
module flash_self_program_control_test;
  logic       clk;         // 250 MHz system clock
  logic       rst;         // Async reset, high
  logic [7:0] addr;        // Register offset
  logic [7:0] wdata;       // Write data
  logic       wr;          // Write strobe
  logic       rd;          // Read strobe
  logic [7:0] rdata;       // Read data
  logic       halt;        // HALT from the CPU model
  logic       stall;       // CPU hold
  logic       hold;        // Pins frozen
  logic [3:0] prot;        // Protect byte, block 1 guarded
  logic [7:0] irq;         // Interrupt requests
  logic [7:0] ack;         // Interrupt acknowledges
  logic [7:0] pend;        // Visible pending requests
  logic       go;          // Start NOP/HALT in the model
  logic       ready;       // Model may issue commands
  int         n_errors;    // Mismatches
  int         num_checks;  // Comparisons

  fspc_top u_dut (
    .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cpu_halt(halt),
    .o_cpu_stall(stall), .o_pin_hold(hold), .i_protect_blocks(prot),
    .i_irq_req(irq), .i_irq_ack(ack), .o_irq_pending(pend));

  fspc_cpu_model u_cpu (
    .i_sys_clk(clk), .i_rst(rst), .i_go(go), .i_stall(stall),
    .o_halt(halt), .o_ready(ready));

  // Free-running clock, 4 ns period
  always #2 clk = ~clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write; an idle cycle follows so strobes never collide
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(16'(rdata), 16'(exp));
  endtask : rd_chk

  // Counts stall cycles in a fixed window, so it cannot hang
  task automatic stall_cnt(input int lim, input int exp);
    int n;
    n = 0;
    repeat (lim) begin
      @(negedge clk);
      if (stall === 1'b1) n++;
    end
    chk(16'(n), 16'(exp));
  endtask : stall_cnt

  // Bounded wait for the model's settle time; the caller checks ready
  task automatic wait_ready(input int lim);
    int n;
    n = 0;
    while ((ready !== 1'b1) && (n < lim)) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_ready

  // Key, value, inverted value: the guarded mode write
  task automatic mode_seq(input logic [7:0] v);
    wr_reg(fspc_pkg::A_PCMD, fspc_pkg::PROT_KEY);
    wr_reg(fspc_pkg::A_PMC, v);
    wr_reg(fspc_pkg::A_PMC, ~v);
  endtask : mode_seq

  // Entry plus NOP/HALT with the automatic release
  task automatic enter_mode;
    wr_reg(fspc_pkg::A_FCMD, fspc_pkg::CMD_NONE);
    mode_seq(8'h01);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask : enter_mode

  // Pulse one interrupt line, or its acknowledge
  task automatic irq_pulse(input logic [7:0] r, input logic [7:0] a);
    @(posedge clk);
    irq <= r;
    ack <= a;
    @(posedge clk);
    irq <= 8'h00;
    ack <= 8'h00;
    repeat (2) @(negedge clk);
  endtask : irq_pulse

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {addr, wdata, irq, ack} = 32'h0;
    {wr, rd, go} = 3'h0;
    prot = 4'h2;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(fspc_pkg::A_MASK, fspc_pkg::RST_MASK);
    wr_reg(8'h3c, 8'h01);
    rd_chk(8'h3c, 8'h00);
    // An unguarded write is refused and flagged
    wr_reg(fspc_pkg::A_PMC, 8'h01);
    rd_chk(fspc_pkg::A_PMC, 8'h00);
    rd_chk(fspc_pkg::A_STAT, 8'h01);
    wr_reg(fspc_pkg::A_STAT, 8'h00);
    wr_reg(fspc_pkg::A_MASK, 8'h00);
    irq_pulse(8'h01, 8'h00);
    chk(16'(pend), 16'h0001);
    irq_pulse(8'h00, 8'h01);
    chk(16'(pend), 16'h0000);
    // Firmware preparation, then entry
    wr_reg(fspc_pkg::A_MASK, 8'hff);
    wr_reg(fspc_pkg::A_APH, 8'h00);
    wr_reg(fspc_pkg::A_APHC, 8'h00);
    enter_mode();
    stall_cnt(2600, fspc_pkg::HALT_REL_CYC);
    wait_ready(2500);
    chk(16'(ready), 16'h0001);
    chk(16'(hold), 16'h0001);
    rd_chk(fspc_pkg::A_PMC, 8'h01);
    irq_pulse(8'h04, 8'h00);
    chk(16'(pend), 16'h0000);
    // Erase, write and blank check on an open block
    wr_reg(fspc_pkg::A_FCMD, fspc_pkg::CMD_ERASE);
    stall_cnt(40, 16);
    wr_reg(fspc_pkg::A_APL, 8'h03);
    rd_chk(fspc_pkg::A_RDAT, fspc_pkg::BLANK_VAL);
    wr_reg(fspc_pkg::A_WDAT, 8'h5a);
    wr_reg(fspc_pkg::A_FCMD, fspc_pkg::CMD_WRITE);
    stall_cnt(40, 16);
    rd_chk(fspc_pkg::A_RDAT, 8'h5a);
    wr_reg(fspc_pkg::A_APL, 8'h02);
    rd_chk(fspc_pkg::A_RDAT, fspc_pkg::BLANK_VAL);
    wr_reg(fspc_pkg::A_FCMD, fspc_pkg::CMD_BLANK);
    stall_cnt(40, 16);
    rd_chk(fspc_pkg::A_STAT, 8'h02);
    wr_reg(fspc_pkg::A_STAT, 8'h00);
    // Both modifying commands refused on the guarded block
    wr_reg(fspc_pkg::A_APH, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wr_reg(fspc_pkg::A_FCMD, i ? fspc_pkg::CMD_WRITE : fspc_pkg::CMD_ERASE);
      stall_cnt(40, 0);
      rd_chk(fspc_pkg::A_STAT, 8'h01);
      wr_reg(fspc_pkg::A_STAT, 8'h00);
    end
    // Exit; the held request shows once unmasked
    // command zeroed before switch
    wr_reg(fspc_pkg::A_FCMD, fspc_pkg::CMD_NONE);
    mode_seq(8'h00);
    rd_chk(fspc_pkg::A_PMC, 8'h00);
    chk(16'(hold), 16'h0000);
    wr_reg(fspc_pkg::A_MASK, 8'h00);
    repeat (2) @(negedge clk);
    chk(16'(pend), 16'h0004);
    // Reset in mid-erase drops back to normal mode
    wr_reg(fspc_pkg::A_APH, 8'h00);
    enter_mode();
    stall_cnt(2600, fspc_pkg::HALT_REL_CYC);
    wait_ready(2500);
    chk(16'(ready), 16'h0001);
    wr_reg(fspc_pkg::A_FCMD, fspc_pkg::CMD_ERASE);
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(16'({stall, hold}), 16'h0000);
    rd_chk(fspc_pkg::A_PMC, 8'h00);
    end_of_test();
  end
endmodule : flash_self_program_control_test
